// >>> hw/osr_defs.svh
// Contract
// - PLL fuse forces PLL on, else soft bit
// - Codes 000x..0111 select LF/MF frequencies
// - Codes 1000..1111 select HF, 1110 PLL 32MHz
// - Clock select: 1x internal, 01 T1, 00 fuse
// - Control bit 2 reads zero
// - T1 ready reads 1 while T1 disabled
// - Status bit 6 shows PLL ready
// - Timeout bit 5 set when on fuse clock
// - HF, MF, LF ready bits 4, 2, 1
// - Lock bit 3 at 2%, stable bit 0
// - Six-bit signed trim, upper bits zero
// - Refclk from sysclk, enabled, feeds modulator
// - Pin gets refclk only when out enabled
// - Eight divider ratios by 3-bit field
// - Divide-by-1 copies source duty unless 0%
// - Slew bit clear removes limiting
// - Reset disables refclk, registers to defaults
// - Crystal mode or clock-out blocks pin
// - Clock-out fuse puts Fosc/4 on pin
// - Divider codes give 1 to 128
// - Duty codes 0/25/50/75%, reset 10
// - Sleep freezes refclk outputs
`ifndef OSR_DEFS_SVH
`define OSR_DEFS_SVH

`define OSR_OFS_CONTROL    12'h000
`define OSR_OFS_STATUS     12'h004
`define OSR_OFS_TUNING     12'h008
`define OSR_OFS_REFCLK     12'h00C

`define OSR_CTL_RESET      8'h38
`define OSR_REF_RESET      8'h30
`define OSR_TRIM_RESET     6'h00
`define OSR_STAT_RESET     8'h80
`define OSR_FREQ_RESET     4'h7
`define OSR_FREQ_PLL_CODE  4'hE
`define OSR_DIV_MAX_LOG    3'h7

`define OSR_RESP_OKAY      2'h0
`define OSR_RESP_SLVERR    2'h2

`endif

// >>> hw/osr_pkg.sv
package osr_pkg;

  typedef enum logic [1:0] {OSR_SRC_FUSE, OSR_SRC_T1, OSR_SRC_INT} osr_src_type;

  typedef enum logic [1:0] {OSR_BAND_LF, OSR_BAND_MF, OSR_BAND_HF} osr_band_type;

  typedef struct packed {
    logic       soft_pll_enable;
    logic [3:0] internal_freq_select;
    logic       unused_zero;
    logic [1:0] sys_clock_select;
  } osr_ctl_type;

  typedef struct packed {
    logic       refclk_enable;
    logic       refclk_out_enable;
    logic       refclk_slew_limit;
    logic [1:0] refclk_duty_select;
    logic [2:0] refclk_divider_select;
  } osr_ref_type;

  typedef struct packed {
    logic t1_osc_ready;
    logic pll_ready;
    logic startup_timeout_status;
    logic hf_osc_ready;
    logic hf_osc_locked;
    logic mf_osc_ready;
    logic lf_osc_ready;
    logic hf_osc_stable;
  } osr_stat_type;

  // Analog side status inputs
  typedef struct packed {
    logic t1_osc_enable;
    logic t1_raw_ready;
    logic pll_locked;
    logic on_fuse_clock;
    logic hf_ready;
    logic hf_within_2pct;
    logic mf_ready;
    logic lf_ready;
    logic hf_within_half_pct;
  } osr_osc_type;

  // Configuration fuses
  typedef struct packed {
    logic pll_fuse_enable;
    logic fuse_instr_clock_out;
    logic crystal_mode;
  } osr_fuse_type;

endpackage

// >>> hw/osr_top.sv
`timescale 1ns/1ps
`include "osr_defs.svh"

module osr_top
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Oscillator status and fuses
  input  wire osr_pkg::osr_osc_type  osc_in,
  input  wire osr_pkg::osr_fuse_type fuse_in,
  input  wire logic                  sleep_mode,
  input  wire logic                  instr_clock,
  // Oscillator controls
  output logic                       pll_enable_ff,
  output osr_pkg::osr_src_type       clock_source_ff,
  output osr_pkg::osr_band_type      osc_band_ff,
  output logic [3:0]                 freq_code_ff,
  output logic                       pll_32mhz_ff,
  output logic [5:0]                 freq_trim_ff,
  // Reference clock
  output logic                       refclk_mod_ff,
  output logic                       refclk_out_pin_ff,
  output logic                       refclk_pin_oe_n_ff,
  output logic                       refclk_slew_ff
);

  // ==========================================================
  // Register storage
  osr_pkg::osr_ctl_type  ctl_ff;
  osr_pkg::osr_ref_type  ref_ff;
  osr_pkg::osr_stat_type stat_ff;
  logic [5:0]            trim_ff;

  logic        aw_held_ff;
  logic        w_held_ff;
  logic [11:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        do_write;
  logic        wr_hit;

  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_hit   = (aw_addr_ff == `OSR_OFS_CONTROL) || (aw_addr_ff == `OSR_OFS_TUNING)
                 || (aw_addr_ff == `OSR_OFS_REFCLK) || (aw_addr_ff == `OSR_OFS_STATUS);

  // ==========================================================
  // Write channel: address and data in either order
  // Each ready pulses once, so a valid still held at the next edge is not taken twice
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      aw_addr_ff    <= 12'h000;
      w_data_ff     <= 32'h0000_0000;
      w_strb_ff     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OSR_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_held_ff && !s_axi_awready)
      begin
        s_axi_awready <= 1'b1;
        aw_held_ff    <= 1'b1;
        aw_addr_ff    <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && !w_held_ff && !s_axi_wready)
      begin
        s_axi_wready <= 1'b1;
        w_held_ff    <= 1'b1;
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `OSR_RESP_OKAY : `OSR_RESP_SLVERR;
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Software registers; status writes are ignored
  // Only the low byte lane carries a register, so only strobe 0 counts
  logic wr_ctl;
  logic wr_trim;
  logic wr_ref;

  assign wr_ctl  = do_write && w_strb_ff[0] && (aw_addr_ff == `OSR_OFS_CONTROL);
  assign wr_trim = do_write && w_strb_ff[0] && (aw_addr_ff == `OSR_OFS_TUNING);
  assign wr_ref  = do_write && w_strb_ff[0] && (aw_addr_ff == `OSR_OFS_REFCLK);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctl_ff <= `OSR_CTL_RESET;
    else if (wr_ctl)
      ctl_ff <= {w_data_ff[7:3], 1'b0, w_data_ff[1:0]};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trim_ff <= `OSR_TRIM_RESET;
    else if (wr_trim)
      trim_ff <= w_data_ff[5:0];
  end

  // A reset always leaves the generator off; firmware sets it up before the pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ref_ff <= `OSR_REF_RESET;
    else if (wr_ref)
      ref_ff <= w_data_ff[7:0];
  end

  // ==========================================================
  // Read channel
  logic [7:0] rd_byte;
  logic       rd_hit;

  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case ({s_axi_araddr[11:2], 2'h0})
      `OSR_OFS_CONTROL: rd_byte = {ctl_ff[7:3], 1'b0, ctl_ff[1:0]};
      `OSR_OFS_STATUS:  rd_byte = stat_ff;
      `OSR_OFS_TUNING:  rd_byte = {2'h0, trim_ff};
      `OSR_OFS_REFCLK:  rd_byte = ref_ff;
      default:          rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `OSR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_byte};
        s_axi_rresp   <= rd_hit ? `OSR_RESP_OKAY : `OSR_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Status register sampling
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stat_ff <= `OSR_STAT_RESET;
    else
    begin
      stat_ff.t1_osc_ready <= osc_in.t1_osc_enable ? osc_in.t1_raw_ready : 1'b1;
      stat_ff.pll_ready              <= osc_in.pll_locked;
      stat_ff.startup_timeout_status <= osc_in.on_fuse_clock;
      stat_ff.hf_osc_ready           <= osc_in.hf_ready;
      stat_ff.mf_osc_ready           <= osc_in.mf_ready;
      stat_ff.lf_osc_ready           <= osc_in.lf_ready;
      stat_ff.hf_osc_locked          <= osc_in.hf_within_2pct;
      stat_ff.hf_osc_stable          <= osc_in.hf_within_half_pct;
    end
  end

  // ==========================================================
  // Oscillator control decode
  logic pll_on;
  assign pll_on = fuse_in.pll_fuse_enable | ctl_ff.soft_pll_enable;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pll_enable_ff <= 1'b0;
      freq_code_ff  <= `OSR_FREQ_RESET;
      pll_32mhz_ff  <= 1'b0;
      freq_trim_ff  <= `OSR_TRIM_RESET;
    end
    else
    begin
      pll_enable_ff <= pll_on;
      freq_code_ff  <= ctl_ff.internal_freq_select;
      freq_trim_ff  <= trim_ff;
      pll_32mhz_ff  <= pll_on && (ctl_ff.internal_freq_select == `OSR_FREQ_PLL_CODE);
    end
  end

  // Codes 0000 and 0001 both run from the slow source
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      osc_band_ff <= osr_pkg::OSR_BAND_MF;
    else if (ctl_ff.internal_freq_select[3])
      osc_band_ff <= osr_pkg::OSR_BAND_HF;
    else if (ctl_ff.internal_freq_select[3:1] == 3'h0)
      osc_band_ff <= osr_pkg::OSR_BAND_LF;
    else
      osc_band_ff <= osr_pkg::OSR_BAND_MF;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      clock_source_ff <= osr_pkg::OSR_SRC_FUSE;
    else if (ctl_ff.sys_clock_select[1])
      clock_source_ff <= osr_pkg::OSR_SRC_INT;
    else if (ctl_ff.sys_clock_select[0])
      clock_source_ff <= osr_pkg::OSR_SRC_T1;
    else
      clock_source_ff <= osr_pkg::OSR_SRC_FUSE;
  end

  // ==========================================================
  // Reference clock generator
  // Divide 1 has no sysclk edge inside a period; the enable gates the source clock.
  logic [7:0] div_cnt_ff;
  logic [7:0] period_last;
  logic [7:0] high_len;
  logic       ref_wave;
  logic       ref_run;

  assign ref_run     = ref_ff.refclk_enable && !sleep_mode;
  assign period_last = 8'((9'h001 << ref_ff.refclk_divider_select) - 9'h001);

  always_comb
  begin
    high_len = 8'h00;
    unique case (ref_ff.refclk_duty_select)
      2'h0: high_len = 8'h00;
      2'h1: high_len = 8'((9'(period_last) + 9'h001) >> 2);
      2'h2: high_len = 8'((9'(period_last) + 9'h001) >> 1);
      2'h3: high_len = 8'(((10'(period_last) + 10'h001) * 10'h003) >> 2);
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ref_ff.refclk_enable)
      div_cnt_ff <= 8'h00;
    else if (ref_run)
      div_cnt_ff <= (div_cnt_ff >= period_last) ? 8'h00 : div_cnt_ff + 8'h01;
  end

  // Divide 1 passes source duty; 0% still forces low
  assign ref_wave = (ref_ff.refclk_divider_select == 3'h0)
                  ? (ref_ff.refclk_duty_select != 2'h0)
                  : (div_cnt_ff < high_len);

  logic ref_level;
  assign ref_level = ref_ff.refclk_enable && ref_wave;

  // Sleep stops the system clock, so every refclk output keeps its level until wake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      refclk_mod_ff  <= 1'b0;
      refclk_slew_ff <= 1'b1;
    end
    else if (!sleep_mode)
    begin
      refclk_mod_ff  <= ref_level;
      refclk_slew_ff <= ref_ff.refclk_slew_limit;
    end
  end

  // The fuse clock outranks the generator; crystal modes need the pin as input
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      refclk_out_pin_ff  <= 1'b0;
      refclk_pin_oe_n_ff <= 1'b1;
    end
    else if (!sleep_mode)
    begin
      if (fuse_in.fuse_instr_clock_out)
      begin
        refclk_out_pin_ff  <= instr_clock;
        refclk_pin_oe_n_ff <= 1'b0;
      end
      else if (fuse_in.crystal_mode || !ref_ff.refclk_out_enable)
      begin
        refclk_out_pin_ff  <= 1'b0;
        refclk_pin_oe_n_ff <= 1'b1;
      end
      else
      begin
        refclk_out_pin_ff  <= ref_level;
        refclk_pin_oe_n_ff <= 1'b0;
      end
    end
  end

endmodule

// >>> test/osr_assertions.sv
`timescale 1ns/1ps
// ====================================================
// Oscillator block checker
module osr_chk
(
  // Clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Bus handshakes
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  // Fuses and pin inputs
  input wire osr_pkg::osr_fuse_type fuse_in,
  input wire logic                  sleep_mode,
  input wire logic                  instr_clock,
  // Watched outputs
  input wire logic                  pll_enable_ff,
  input wire osr_pkg::osr_band_type osc_band_ff,
  input wire logic [3:0]            freq_code_ff,
  input wire logic                  pll_32mhz_ff,
  input wire logic                  refclk_mod_ff,
  input wire logic                  refclk_out_pin_ff,
  input wire logic                  refclk_pin_oe_n_ff,
  input wire logic                  refclk_slew_ff
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held too long");
  a_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read data late");
  a_pll_forced: assert property (fuse_in.pll_fuse_enable |=> pll_enable_ff)
    else $error("pll not forced on");
  a_band_decode: assert property (osc_band_ff == (freq_code_ff[3] ? osr_pkg::OSR_BAND_HF :
    (freq_code_ff[3:1] == 3'h0 ? osr_pkg::OSR_BAND_LF : osr_pkg::OSR_BAND_MF)))
    else $error("band decode wrong");
  a_pll_fast: assert property (pll_32mhz_ff == (freq_code_ff == 4'hE && pll_enable_ff))
    else $error("fast pll flag wrong");
  a_reset_state: assert property ($rose(aresetn) |-> refclk_pin_oe_n_ff &&
    !refclk_out_pin_ff && !refclk_mod_ff && refclk_slew_ff && freq_code_ff == 4'h7)
    else $error("reset state wrong");
  a_pin_blocked: assert property (fuse_in.crystal_mode && !fuse_in.fuse_instr_clock_out &&
    !sleep_mode |=> refclk_pin_oe_n_ff && !refclk_out_pin_ff)
    else $error("pin driven in crystal mode");
  a_instr_clock_out_function_pin: assert property (fuse_in.fuse_instr_clock_out && !sleep_mode |=>
    !refclk_pin_oe_n_ff && refclk_out_pin_ff == $past(instr_clock))
    else $error("instruction clock not on pin");
  a_sleep_hold: assert property (sleep_mode |=> $stable(refclk_mod_ff) &&
    $stable(refclk_out_pin_ff) && $stable(refclk_pin_oe_n_ff))
    else $error("outputs moved in sleep");
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
  // ====================================================
  // Signals
  typedef struct packed
  {
    logic [11:0] a;
    logic [7:0]  d;
    logic [8:0]  o;
    logic [7:0]  e;
    logic [1:0]  r;
  } osr_row_type;
  localparam osr_row_type TBL [9] = '{
    '{12'h000, 8'hFF, 9'h000, 8'hFB, 2'h0}, '{12'h008, 8'hFF, 9'h000, 8'h3F, 2'h0},
    '{12'h008, 8'h20, 9'h000, 8'h20, 2'h0}, '{12'h00C, 8'hA5, 9'h000, 8'hA5, 2'h0},
    '{12'h004, 8'h55, 9'h1FF, 8'hFF, 2'h0}, '{12'h004, 8'hFF, 9'h000, 8'h80, 2'h0},
    '{12'h004, 8'h00, 9'h100, 8'h00, 2'h0}, '{12'h004, 8'h00, 9'h0AA, 8'hAA, 2'h0},
    '{12'h010, 8'hFF, 9'h000, 8'h00, 2'h2}};
  logic                  aclk, aresetn, sleep_mode, instr_clock, pll_enable_ff, pll_32mhz_ff;
  logic [11:0]           s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata, got;
  logic [3:0]            s_axi_wstrb, freq_code_ff;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  logic [1:0]            s_axi_bresp, s_axi_rresp, resp;
  logic [5:0]            freq_trim_ff;
  logic                  refclk_mod_ff, refclk_out_pin_ff, refclk_pin_oe_n_ff, refclk_slew_ff;
  osr_pkg::osr_osc_type  osc_in;
  osr_pkg::osr_fuse_type fuse_in;
  osr_pkg::osr_src_type  clock_source_ff;
  osr_pkg::osr_band_type osc_band_ff;
  int                    fails, checks_done, m, p, xp;

  osr_top i_dut (.*);

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) instr_clock <= ~instr_clock;

  // ====================================================
  // Tasks
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    got = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Long settle: after a divider change the count may run on to the new period's end
  task automatic meas();
    m = 0;
    p = 0;
    repeat (130) @(posedge aclk);
    repeat (256)
    begin
      @(posedge aclk);
      m += refclk_mod_ff;
      p += refclk_out_pin_ff;
    end
  endtask
  task automatic rst();
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK({refclk_pin_oe_n_ff, refclk_out_pin_ff, refclk_slew_ff}, 3'b101)
    rdr(12'h00C);
    `CHK(got, 32'h30)
    rdr(12'h000);
    `CHK(got, 32'h38)
  endtask
  task automatic close_out();
    $display("Checks %0d, errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge aclk);
    fails++;
    close_out();
  end

  // ====================================================
  // Sequence
  initial
  begin
    {aresetn, sleep_mode, instr_clock, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    osc_in = 9'h000;
    fuse_in = 3'b000;
    rst();
    for (int i = 0; i < 9; i++)
    begin
      osc_in <= TBL[i].o;
      wr(TBL[i].a, TBL[i].d);
      `CHK(resp, TBL[i].r)
      rdr(TBL[i].a);
      `CHK({resp, resp == 2'h0 ? got : 32'h0}, {TBL[i].r, 24'h0, TBL[i].e})
    end
    `CHK(freq_trim_ff, 6'h20)
    for (int i = 0; i < 128; i++)
    begin
      wr(12'h000, {i[6], i[5:2], 1'b0, i[1:0]});
      `CHK(clock_source_ff, i[1] ? osr_pkg::OSR_SRC_INT : (i[0] ? osr_pkg::OSR_SRC_T1 : osr_pkg::OSR_SRC_FUSE))
      `CHK(osc_band_ff, i[5] ? osr_pkg::OSR_BAND_HF : (i[5:3] == 0 ? osr_pkg::OSR_BAND_LF : osr_pkg::OSR_BAND_MF))
      `CHK({freq_code_ff, pll_enable_ff, pll_32mhz_ff}, {i[5:2], i[6], i[6] && i[5:2] == 4'hE})
    end
    fuse_in <= 3'b100;
    wr(12'h000, 8'h70);
    `CHK(pll_enable_ff, 1'b1)
    fuse_in <= 3'b000;
    for (int i = 0; i < 32; i++)
    begin
      wr(12'h00C, {3'b110, i[4:3], i[2:0]});
      meas();
      xp = i[2:0] == 0 ? (i[4:3] != 0 ? 256 : 0) : 64 * i[4:3];
      if (i[2:0] != 1 || !i[3]) `CHK({m, p}, {xp, xp})
      `CHK({refclk_pin_oe_n_ff, refclk_slew_ff}, 2'b00)
    end
    wr(12'h00C, 8'hB2);
    meas();
    `CHK({m, p, refclk_pin_oe_n_ff, refclk_slew_ff}, {32'd128, 32'd0, 2'b11})
    wr(12'h00C, 8'h52);
    meas();
    `CHK({m, p}, {32'd0, 32'd0})
    wr(12'h00C, 8'hD2);
    fuse_in <= 3'b001;
    meas();
    `CHK({m, p, refclk_pin_oe_n_ff}, {32'd128, 32'd0, 1'b1})
    fuse_in <= 3'b010;
    meas();
    `CHK({m, p, refclk_pin_oe_n_ff}, {32'd128, 32'd128, 1'b0})
    fuse_in <= 3'b000;
    sleep_mode <= 1'b1;
    meas();
    `CHK(m % 256, 0)
    sleep_mode <= 1'b0;
    aresetn <= 1'b0;
    rst();
    close_out();
  end
endmodule

bind osr_top osr_chk i_chk (.*);
